// file: hw/urx_defines.svh
// constants for the receive holding path and flow-control block
// assumes a 16x sampling enable from the baud generator outside
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

`define URX_FIFO_DEPTH      5'h10
`define URX_PTR_W           4
`define URX_CNT_W           5
`define URX_ENTRY_W         11
`define URX_BIT_TICKS       4'hF
`define URX_IR_PULSE_TICKS  4'h3
`define URX_FRAME_BASE      4'h7
`define URX_XOFF_CHARS      10'h002
`define URX_XON1            2'h0
`define URX_XON2            2'h1
`define URX_XOFF1           2'h2
`define URX_XOFF2           2'h3
`define URX_TRIG_L0         5'h01
`define URX_TRIG_L1         5'h04
`define URX_TRIG_L2         5'h08
`define URX_TRIG_L3         5'h0E
`define URX_XON_L0          5'h00
`define URX_XON_L1          5'h01
`define URX_XON_L2          5'h04
`define URX_XON_L3          5'h08

`endif

// file: hw/urx_pkg.sv
// types shared by the receive holding and flow-control block
// assumes urx_defines.svh is on the include path
package urx_pkg;

    typedef struct packed {
        logic [2:0] err;
        logic [7:0] data;
    } urx_char_t;

    typedef enum logic [1:0] {
        SW_OFF,
        SW_SINGLE1,
        SW_SINGLE2,
        SW_DOUBLE
    } urx_swmode_t;

    typedef struct packed {
        logic        auto_cts;
        logic        auto_rts;
        logic        spec_det;
        logic        unlock;
        logic        auto_xoff;
        urx_swmode_t sw_rx_mode;
    } urx_efr_t;

    typedef struct packed {
        logic cts_int;
        logic rts_int;
        logic xoff_int;
    } urx_ier_t;

    typedef enum logic [1:0] {
        XS_IDLE,
        XS_WAIT,
        XS_SENT
    } urx_xstate_t;

    typedef struct packed {
        logic [3:0]      phase;
        logic            tx_q;
        logic            tx_pin;
        logic            rx_q;
        logic [3:0]      rx_cnt;
        logic            rx_out;
    } urx_ir_state_t;

    typedef struct packed {
        logic [3:0]      wr_ptr;
        logic [3:0]      rd_ptr;
        logic [4:0]      count;
        logic            data_ready;
        logic [3:0][7:0] xchar;
        logic            rts_n;
        logic            rts_armed;
        logic            rts_blocked;
        logic            mcr_rts_q;
        logic            cts_q;
        logic            fc_int;
        logic            xoff_flag;
        logic            spec_flag;
        logic            tx_halt_sw;
        logic            tx_hold;
        logic            pend_valid;
        urx_char_t       pend;
        logic            late_valid;
        urx_char_t       late;
        urx_xstate_t     xstate;
        logic [9:0]      delay;
        logic            send_xoff;
        logic            send_xon;
        logic            int_out;
    } urx_state_t;

endpackage : urx_pkg

// file: hw/urx_fifo_mem.sv
// storage for the sixteen receive entries, data plus error tags
// assumes one writer and one reader in the same clock
`timescale 1ns/1ps
`include "urx_defines.svh"
module urx_fifo_mem
    import urx_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_we,
    input  wire logic [`URX_PTR_W-1:0] i_waddr,
    input  wire urx_char_t             i_wdata,
    input  wire logic [`URX_PTR_W-1:0] i_raddr,
    output urx_char_t                  o_rdata
);
    urx_char_t mem [16];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // bypass so a write into an empty queue shows at the head at once
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata <= '0;
        end else if (i_we && i_waddr == i_raddr) begin
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : urx_fifo_mem

// file: hw/urx_irda.sv
// infrared pulse encoder and decoder on the serial pins
// assumes i_tick16 is a one-cycle pulse at sixteen times the bit rate
`timescale 1ns/1ps
`include "urx_defines.svh"
module urx_irda
    import urx_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic i_tick16,
    input  wire logic i_irda,
    input  wire logic i_tx_serial,
    input  wire logic i_rx_pin,
    output logic      o_tx_pin,
    output logic      o_rx_data
);
    urx_ir_state_t s;
    urx_ir_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.rx_q = i_rx_pin;
        if (i_tick16) begin
            next_s.tx_q = i_tx_serial;
            // realign the bit phase on every data edge
            if (i_tx_serial != s.tx_q) begin
                next_s.phase = 4'h0;
            end else begin
                next_s.phase = s.phase + 4'h1;
            end
        end
        if (i_irda) begin
            next_s.tx_pin = !i_tx_serial
                && (next_s.phase < `URX_IR_PULSE_TICKS);
        end else begin
            next_s.tx_pin = i_tx_serial;
        end
        if (!i_irda) begin
            next_s.rx_cnt = 4'h0;
            next_s.rx_out = i_rx_pin;
        end else if (i_rx_pin && !s.rx_q) begin
            next_s.rx_cnt = `URX_BIT_TICKS;
            next_s.rx_out = 1'b0;
        end else if (i_tick16 && s.rx_cnt != 4'h0) begin
            next_s.rx_cnt = s.rx_cnt - 4'h1;
        end else if (s.rx_cnt == 4'h0) begin
            next_s.rx_out = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_tx_pin  = s.tx_pin;
    assign o_rx_data = s.rx_out;

    a_ir_pulse_phase: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (o_tx_pin && $past(i_irda)) |-> (s.phase < `URX_IR_PULSE_TICKS))
        else $error("infrared pulse outside its three tick window");

    a_ir_tx_idle: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        ($past(i_irda) && $past(i_tx_serial)) |-> !o_tx_pin)
        else $error("infrared transmit not idle low on a one bit");

    a_ir_rx_decode: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_irda && i_rx_pin && !s.rx_q) |=> !o_rx_data)
        else $error("infrared pulse not decoded as a zero bit");
endmodule : urx_irda

// file: hw/urx_top.sv
// receive holding queue, auto RTS/CTS, Xon/Xoff and infrared paths
// assumes a receive shift register and transmitter outside this block
// Overview of operation
// - keep received characters in a 16 deep queue of 11 bit entries
// - with the queue enabled, holding register shows the oldest entry
// - a holding read loads the next entry and its three error tags
// - automatic RTS control is switched on by its enhanced feature bit
// - automatic RTS starts only after RTS control bit is set afterwards
// - with unlock and RTS interrupt enabled, RTS rising sets flow flag
// - automatic CTS control is switched on by its enhanced feature bit
// - with CTS interrupt enabled after unlock, CTS going high sets flag
// - CTS high halts transmitter after current stop bit; low resumes it
// - RTS rises at the upper fill threshold, returns low at the lower one
// - received Xoff match halts transmission after current character
// - with Xoff interrupt enabled, Xoff match sets flag and interrupt; later Xon resumes and clears
// - reset zeroes the Xon and Xoff characters; host may write any
// - double mode needs two consecutive matching characters
// - characters used for flow control never enter the queue
// - crossing the trigger sends Xoff two character times later
// - Xon is sent at fill 0, 1, 4, 8 for triggers 1, 4, 8, 14
// - special detect stores the second Xoff match and sets its flag
// - comparisons use only the programmed word length bits, LSB first
// - infrared encoder sends a 3/16 bit high pulse per zero bit
// - infrared mode idles transmit low and treats receive low as idle
// - one bit time is sixteen 16x ticks, timing pulses and delays
`timescale 1ns/1ps
`include "urx_defines.svh"
module urx_top
    import urx_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    input  wire logic       i_tick16,
    input  wire logic       i_rx_valid,
    input  wire urx_char_t  i_rx_char,
    input  wire logic       i_rhr_rd,
    input  wire logic       i_isr_rd,
    input  wire logic       i_fifo_en,
    input  wire logic [1:0] i_trig_sel,
    input  wire logic [1:0] i_word_len,
    input  wire urx_efr_t   i_efr,
    input  wire urx_ier_t   i_ier,
    input  wire logic       i_mcr_rts,
    input  wire logic       i_mcr_irda,
    input  wire logic       i_xreg_wr,
    input  wire logic [1:0] i_xreg_sel,
    input  wire logic [7:0] i_xreg_wdata,
    input  wire logic       i_cts_n,
    input  wire logic       i_tx_serial,
    input  wire logic       i_rx_pin,
    output urx_char_t       o_rhr,
    output logic [4:0]      o_fifo_count,
    output logic            o_data_ready,
    output logic            o_rts_n,
    output logic            o_tx_hold,
    output logic            o_send_xoff,
    output logic            o_send_xon,
    output logic            o_fc_int,
    output logic            o_xoff_flag,
    output logic            o_spec_flag,
    output logic            o_int,
    output logic            o_tx_pin,
    output logic            o_rx_data
);
    urx_state_t s;
    urx_state_t next_s;
    urx_char_t  push_char;
    logic       push;
    logic       push_ok;
    logic       pop;
    logic       xoff_hit;
    logic       xon_hit;
    logic       m_xon1;
    logic       m_xon2;
    logic       m_xoff1;
    logic       m_xoff2;
    logic       p_xon1;
    logic       p_xoff1;
    logic [4:0] cap;
    logic [4:0] trig;
    logic [4:0] lower;

    function automatic logic char_match(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [1:0] wl);
        logic [7:0] mask;
        mask = 8'hFF >> (2'h3 - wl);
        return ((a ^ b) & mask) == 8'h00;
    endfunction : char_match

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: return `URX_TRIG_L0;
            2'h1: return `URX_TRIG_L1;
            2'h2: return `URX_TRIG_L2;
            2'h3: return `URX_TRIG_L3;
        endcase
    endfunction : trig_level

    function automatic logic [4:0] xon_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: return `URX_XON_L0;
            2'h1: return `URX_XON_L1;
            2'h2: return `URX_XON_L2;
            2'h3: return `URX_XON_L3;
        endcase
    endfunction : xon_level

    // two frames of start, data and stop bits, sixteen ticks per bit
    function automatic logic [9:0] char_delay(input logic [1:0] wl);
        logic [9:0] bits;
        bits = 10'({`URX_FRAME_BASE} + {2'h0, wl});
        return 10'(bits * `URX_XOFF_CHARS * 10'h010);
    endfunction : char_delay

    always_comb begin
        next_s    = s;
        push      = 1'b0;
        push_char = '0;
        xoff_hit  = 1'b0;
        xon_hit   = 1'b0;
        trig      = trig_level(i_trig_sel);
        lower     = xon_level(i_trig_sel);
        m_xon1    = char_match(i_rx_char.data, s.xchar[`URX_XON1], i_word_len);
        m_xon2    = char_match(i_rx_char.data, s.xchar[`URX_XON2], i_word_len);
        m_xoff1   = char_match(i_rx_char.data, s.xchar[`URX_XOFF1],
                               i_word_len);
        m_xoff2   = char_match(i_rx_char.data, s.xchar[`URX_XOFF2],
                               i_word_len);
        p_xon1    = char_match(s.pend.data, s.xchar[`URX_XON1], i_word_len);
        p_xoff1   = char_match(s.pend.data, s.xchar[`URX_XOFF1], i_word_len);
        next_s.send_xoff = 1'b0;
        next_s.send_xon  = 1'b0;
        next_s.cts_q     = i_cts_n;
        next_s.mcr_rts_q = i_mcr_rts;
        // host clears first so that a same-cycle event still sets below
        if (i_isr_rd) begin
            next_s.fc_int    = 1'b0;
            next_s.spec_flag = 1'b0;
        end
        if (i_xreg_wr) begin
            next_s.xchar[i_xreg_sel] = i_xreg_wdata;
        end
        if (s.late_valid) begin
            push              = 1'b1;
            push_char         = s.late;
            next_s.late_valid = 1'b0;
        end
        if (i_rx_valid) begin
            if (i_efr.spec_det && m_xoff2) begin
                next_s.spec_flag = 1'b1;
            end
            unique case (i_efr.sw_rx_mode)
                SW_OFF: begin
                    push      = 1'b1;
                    push_char = i_rx_char;
                end
                SW_SINGLE1: begin
                    if (m_xoff1) begin
                        xoff_hit = 1'b1;
                    end else if (m_xon1) begin
                        xon_hit = 1'b1;
                    end else begin
                        push      = 1'b1;
                        push_char = i_rx_char;
                    end
                end
                SW_SINGLE2: begin
                    if (m_xoff2 && !i_efr.spec_det) begin
                        xoff_hit = 1'b1;
                    end else if (m_xon2) begin
                        xon_hit = 1'b1;
                    end else begin
                        push      = 1'b1;
                        push_char = i_rx_char;
                    end
                end
                SW_DOUBLE: begin
                    // a possible first half waits for the next character
                    if (s.pend_valid) begin
                        next_s.pend_valid = 1'b0;
                        if (p_xoff1 && m_xoff2) begin
                            xoff_hit = 1'b1;
                        end else if (p_xon1 && m_xon2) begin
                            xon_hit = 1'b1;
                        end else begin
                            push      = 1'b1;
                            push_char = s.pend;
                            if (m_xon1 || m_xoff1) begin
                                next_s.pend_valid = 1'b1;
                                next_s.pend       = i_rx_char;
                            end else begin
                                next_s.late_valid = 1'b1;
                                next_s.late       = i_rx_char;
                            end
                        end
                    end else if (m_xon1 || m_xoff1) begin
                        next_s.pend_valid = 1'b1;
                        next_s.pend       = i_rx_char;
                    end else begin
                        push      = 1'b1;
                        push_char = i_rx_char;
                    end
                end
            endcase
        end
        if (xoff_hit) begin
            next_s.tx_halt_sw = 1'b1;
            if (i_ier.xoff_int) begin
                next_s.xoff_flag = 1'b1;
            end
        end
        if (xon_hit) begin
            next_s.tx_halt_sw = 1'b0;
            next_s.xoff_flag  = 1'b0;
        end

        // non-queue mode behaves as a single holding entry
        cap     = i_fifo_en ? `URX_FIFO_DEPTH : 5'h01;
        pop     = i_rhr_rd && (s.count != 5'h00);
        push_ok = push && ((s.count < cap) || pop);
        next_s.count = 5'(s.count + {4'h0, push_ok} - {4'h0, pop});
        if (push_ok) begin
            next_s.wr_ptr = s.wr_ptr + 4'h1;
        end
        if (pop) begin
            next_s.rd_ptr = s.rd_ptr + 4'h1;
        end
        next_s.data_ready = next_s.count != 5'h00;

        if (next_s.count >= trig) begin
            next_s.rts_blocked = 1'b1;
        end else if (next_s.count <= lower) begin
            next_s.rts_blocked = 1'b0;
        end
        if (!i_efr.auto_rts) begin
            next_s.rts_armed = 1'b0;
        end else if (i_mcr_rts && !s.mcr_rts_q) begin
            next_s.rts_armed = 1'b1;
        end
        next_s.rts_n = !(i_mcr_rts && !(i_efr.auto_rts
                       && next_s.rts_armed && next_s.rts_blocked));
        if (i_efr.unlock && i_ier.rts_int && !s.rts_n && next_s.rts_n) begin
            next_s.fc_int = 1'b1;
        end
        if (i_efr.unlock && i_ier.cts_int && i_cts_n && !s.cts_q) begin
            next_s.fc_int = 1'b1;
        end
        // the transmitter samples this only between characters
        next_s.tx_hold = (i_efr.auto_cts && i_cts_n)
                         || next_s.tx_halt_sw;

        unique case (s.xstate)
            XS_IDLE: begin
                if (i_efr.auto_xoff && s.count < trig
                    && next_s.count >= trig) begin
                    next_s.xstate = XS_WAIT;
                    next_s.delay  = char_delay(i_word_len);
                end
            end
            XS_WAIT: begin
                if (i_tick16) begin
                    if (s.delay <= 10'h001) begin
                        next_s.send_xoff = 1'b1;
                        next_s.xstate    = XS_SENT;
                    end else begin
                        next_s.delay = s.delay - 10'h001;
                    end
                end
            end
            XS_SENT: begin
                if (next_s.count <= lower) begin
                    next_s.send_xon = 1'b1;
                    next_s.xstate   = XS_IDLE;
                end
            end
        endcase
        if (!i_efr.auto_xoff) begin
            next_s.xstate = XS_IDLE;
        end
        next_s.int_out = next_s.fc_int || next_s.xoff_flag
                         || next_s.spec_flag;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s       <= '0;
            s.rts_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    urx_fifo_mem u_mem (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_we     (push_ok),
        .i_waddr  (s.wr_ptr),
        .i_wdata  (push_char),
        .i_raddr  (next_s.rd_ptr),
        .o_rdata  (o_rhr)
    );

    urx_irda u_irda (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_tick16    (i_tick16),
        .i_irda      (i_mcr_irda),
        .i_tx_serial (i_tx_serial),
        .i_rx_pin    (i_rx_pin),
        .o_tx_pin    (o_tx_pin),
        .o_rx_data   (o_rx_data)
    );

    assign o_fifo_count = s.count;
    assign o_data_ready = s.data_ready;
    assign o_rts_n      = s.rts_n;
    assign o_tx_hold    = s.tx_hold;
    assign o_send_xoff  = s.send_xoff;
    assign o_send_xon   = s.send_xon;
    assign o_fc_int     = s.fc_int;
    assign o_xoff_flag  = s.xoff_flag;
    assign o_spec_flag  = s.spec_flag;
    assign o_int        = s.int_out;

    a_fifo_depth_bound: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (s.count <= `URX_FIFO_DEPTH) && (i_fifo_en || s.count <= 5'h01))
        else $error("receive queue count beyond sixteen");

    a_rts_threshold: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_efr.auto_rts && s.rts_armed && s.count >= trig && !i_rhr_rd)
        |=> o_rts_n)
        else $error("RTS still asserted at the upper threshold");

    a_rts_needs_mcr: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        !i_mcr_rts |=> o_rts_n)
        else $error("RTS asserted without its control bit");

    a_rts_rise_int: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        ($rose(o_rts_n) && $past(i_efr.unlock && i_ier.rts_int))
        |-> o_fc_int)
        else $error("RTS rise did not set the flow flag");

    a_cts_rise_int: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_efr.unlock && i_ier.cts_int && i_cts_n && !s.cts_q)
        |=> o_fc_int)
        else $error("CTS deassert did not set the flow flag");

    a_cts_hold_tx: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_efr.auto_cts && i_cts_n) |=> o_tx_hold)
        else $error("transmit not held while CTS high");

    a_xoff_halts: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        xoff_hit |=> o_tx_hold)
        else $error("Xoff match did not halt transmission");

    a_xon_clears: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        xon_hit |=> (!o_xoff_flag && !s.tx_halt_sw))
        else $error("Xon match did not clear the flag");

    a_xchar_reset: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        $rose(i_resetn) |-> (s.xchar == '0))
        else $error("flow characters not zero after reset");

    a_flow_not_stored: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        ((xoff_hit || xon_hit) && !s.late_valid) |-> !push_ok)
        else $error("flow character written into the queue");

    a_xoff_after_wait: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        o_send_xoff |-> ($past(s.xstate) == XS_WAIT && $past(i_tick16)))
        else $error("Xoff sent without the character delay");
endmodule : urx_top

// file: verif/urx_remote.sv
// remote serial device that hands finished characters to the block
// assumes the bench raises i_go for one cycle per character
`timescale 1ns/1ps
module urx_remote
    import urx_pkg::*;
(
    input  wire logic      i_mclk,
    input  wire logic      i_go,
    input  wire urx_char_t i_char,
    input  wire logic      i_rts_n,
    output logic           o_valid,
    output urx_char_t      o_char
);
    urx_char_t last = '0;
    // the remote end holds off while our rts is deasserted
    assign o_valid = i_go & ~i_rts_n;
    // an idle line must not repeat the last character
    assign o_char = i_go ? i_char : ~last;
    always @(posedge i_mclk) if (i_go) last <= i_char;
endmodule : urx_remote

// file: verif/tb_urx_top.sv
// self-checking bench with a queue model of the receive path
// assumes urx_top and urx_remote are compiled before it
`timescale 1ns/1ps
module tb_urx_top
    import urx_pkg::*;
;
    logic i_mclk = 0, i_resetn = 0, go = 0, i_rhr_rd = 0, i_isr_rd = 0;
    logic i_fifo_en = 1, i_mcr_rts = 0, i_xreg_wr = 0, i_cts_n = 0;
    logic [1:0] i_trig_sel = 0, i_xreg_sel = 0;
    logic [7:0] i_xreg_wdata = 0;
    urx_char_t ch = '0, i_rx_char, o_rhr;
    urx_efr_t i_efr = '0;
    urx_ier_t i_ier = '0;
    logic i_rx_valid, o_rts_n, o_tx_hold, o_fc_int, o_xoff_flag, o_int;
    logic [4:0] o_fifo_count;
    logic irda = 0, rxp = 0, rxd, o_data_ready, o_spec_flag;
    int failures = 0, compares = 0, cyc = 0;
    int q[$];
    always #4 i_mclk = ~i_mclk;
    urx_top u_dut (.i_mclk, .i_resetn, .i_tick16(1'b0), .i_rx_valid,
        .i_rx_char, .i_rhr_rd, .i_isr_rd, .i_fifo_en, .i_trig_sel,
        .i_word_len(2'h3), .i_efr, .i_ier, .i_mcr_rts, .i_mcr_irda(irda),
        .i_xreg_wr, .i_xreg_sel, .i_xreg_wdata, .i_cts_n,
        .i_tx_serial(1'b1), .i_rx_pin(rxp), .o_rhr, .o_fifo_count,
        .o_data_ready, .o_rts_n, .o_tx_hold, .o_send_xoff(),
        .o_send_xon(), .o_fc_int, .o_xoff_flag, .o_spec_flag, .o_int,
        .o_tx_pin(), .o_rx_data(rxd));
    urx_remote u_rem (.i_mclk, .i_go(go), .i_char(ch), .i_rts_n(o_rts_n),
        .o_valid(i_rx_valid), .o_char(i_rx_char));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    // keep says whether the model expects the character to be stored
    task automatic send(input logic [10:0] c, input bit keep);
        if (keep && o_rts_n === 1'b0 && q.size() < 16) q.push_back(c);
        go = 1;
        ch = c;
        @(negedge i_mclk);
        go = 0;
        @(negedge i_mclk);
    endtask : send
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            final_report;
        end
    end
    initial begin
        void'($urandom(29));
        repeat (12) @(negedge i_mclk);
        i_resetn = 1;
        chk(o_rts_n, 1);
        i_mcr_rts = 1;
        @(negedge i_mclk);
        for (int i = 0; i < 17; i++) send(11'($urandom), 1);
        chk(o_fifo_count, 16);
        i_rhr_rd = 1;
        while (q.size() > 0) begin
            chk(o_rhr, 16'(q[0]));
            void'(q.pop_front());
            @(negedge i_mclk);
            chk(o_fifo_count, 16'(q.size()));
        end
        @(negedge i_mclk);
        i_rhr_rd = 0;
        chk({o_fifo_count, o_data_ready}, 0);
        i_efr.auto_rts = 1;
        i_efr.unlock = 1;
        i_ier.rts_int = 1;
        i_trig_sel = 1;
        i_mcr_rts = 0;
        @(negedge i_mclk);
        i_mcr_rts = 1;
        repeat (2) @(negedge i_mclk);
        for (int i = 0; i < 6; i++) send(11'($urandom), 1);
        chk(o_fifo_count, 4);
        chk(o_rts_n, 1);
        chk(o_fc_int, 1);
        i_isr_rd = 1;
        i_rhr_rd = 1;
        repeat (3) @(negedge i_mclk);
        i_isr_rd = 0;
        i_rhr_rd = 0;
        repeat (3) void'(q.pop_front());
        @(negedge i_mclk);
        chk(o_rts_n, 0);
        chk(o_fc_int, 0);
        i_efr.sw_rx_mode = SW_SINGLE1;
        i_ier.xoff_int = 1;
        send(11'h000, 0);
        chk(o_fifo_count, 16'(q.size()));
        chk({o_tx_hold, o_xoff_flag, o_int}, 3'h7);
        for (int s = 0; s < 3; s += 2) begin
            i_xreg_wr = 1;
            i_xreg_sel = 2'(s);
            i_xreg_wdata = 8'h11 + 8'(s);
            @(negedge i_mclk);
            i_xreg_wr = 0;
        end
        // end on an Xon so the CTS hold below is seen on its own
        for (int k = 0; k < 4; k++) begin
            send(11'h013 - 11'(k[0] * 2), 0);
            chk({o_tx_hold, o_xoff_flag}, {2{~k[0]}});
        end
        send(11'h055, 1);
        chk(o_fifo_count, 16'(q.size()));
        i_efr.spec_det = 1;
        send(11'h000, 1);
        chk({o_spec_flag, o_data_ready}, 2'h3);
        chk(o_fifo_count, 16'(q.size()));
        i_efr.auto_cts = 1;
        i_ier.cts_int = 1;
        i_cts_n = 1;
        repeat (2) @(negedge i_mclk);
        chk({o_tx_hold, o_fc_int}, 2'h3);
        i_cts_n = 0;
        repeat (2) @(negedge i_mclk);
        chk(o_tx_hold, 0);
        irda = 1;
        repeat (2) @(negedge i_mclk);
        chk(rxd, 1);
        rxp = 1;
        @(negedge i_mclk);
        rxp = 0;
        chk(rxd, 0);
        final_report;
    end
endmodule : tb_urx_top
